// ===== pkg/wdrl_consts.svh
// Offsets, fields, reset values and counts for the watchdog reload/lock block.
// Included by the package and the design; definitions only.
`ifndef WDRL_CONSTS_SVH
`define WDRL_CONSTS_SVH

`define WDRL_ADDR_W          4
`define WDRL_OFF_CTRL        4'h0
`define WDRL_OFF_UPPER       4'h1
`define WDRL_OFF_HIGH        4'h2
`define WDRL_OFF_LOW         4'h3
`define WDRL_OFF_CAUSE       4'h4
`define WDRL_OFF_COUNT_U     4'h5
`define WDRL_OFF_COUNT_H     4'h6
`define WDRL_OFF_COUNT_L     4'h7
`define WDRL_OFF_IRQ_STAT    4'h8
`define WDRL_OFF_IRQ_CLR     4'h9
`define WDRL_OFF_IRQ_EN      4'ha

`define WDRL_UNLOCK_1        8'h55
`define WDRL_UNLOCK_2        8'haa

`define WDRL_CTRL_EN_BIT     0
`define WDRL_CTRL_RST_BIT    1
`define WDRL_CTRL_RESET      8'h00

`define WDRL_CAUSE_STOP_BIT  5
`define WDRL_CAUSE_WDT_BIT   6
`define WDRL_CAUSE_RESET     8'h00

`define WDRL_IRQ_TIMEOUT_BIT 0
`define WDRL_IRQ_NORM_BIT    1
`define WDRL_IRQ_STOP_BIT    2
`define WDRL_IRQ_W           3

`define WDRL_RELOAD_RESET    24'h000400

`endif

// ===== pkg/wdrl_pkg.sv
// Types for the watchdog reload/lock block.
// Constants live in wdrl_consts.svh.
`include "wdrl_consts.svh"

package wdrl_pkg;

  typedef enum logic [1:0] {
    WDRL_LOCKED,
    WDRL_GOT_55,
    WDRL_OPEN_UPPER,
    WDRL_OPEN_HIGH
  } wdrl_lock_e;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] high;
    logic [7:0] low;
  } wdrl_reload_s;

  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`WDRL_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
  } wdrl_bus_s;

endpackage : wdrl_pkg

// ===== hw/wdrl_watchdog.sv
// Watchdog counter with locked reload registers and stop-aware time-out reset.
// Assumes a CPU-side register port in the clk domain and a count tick already
// synchronised to clk; refresh is a one-cycle pulse from the core.
//
// Operation
// - Reset time-out while stopped requests stop-mode recovery, not system reset.
// - Stop-mode reset time-out sets watchdog cause and stop flags.
// - Unlock writes leave every stored control bit unchanged.
// - Any other intervening write, except a repeated 0x55, returns the lock machine to locked.
// - Reload byte writes are ignored while locked.
// - Counter loads reload value on first enable and on each refresh.
// - Reset time-out in normal operation requests system reset, sets cause flag.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "wdrl_consts.svh"

module wdrl_watchdog (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    wr,
  input  wire logic                    rd,
  input  wire logic [`WDRL_ADDR_W-1:0] addr,
  input  wire logic [7:0]              wdata,
  output logic      [7:0]              rdata,
  input  wire logic                    count_tick,
  input  wire logic                    refresh,
  input  wire logic                    stop_mode,
  output logic                         sys_reset_req,
  output logic                         stop_recovery_req,
  output logic                         irq
);

  wdrl_pkg::wdrl_bus_s    bus;
  wdrl_pkg::wdrl_lock_e   lock_state;
  wdrl_pkg::wdrl_lock_e   next_lock_state;
  wdrl_pkg::wdrl_reload_s reload;
  logic [7:0]             ctrl;
  logic [7:0]             cause;
  logic [23:0]            count;
  logic                   enabled_q;
  logic [`WDRL_IRQ_W-1:0] irq_stat;
  logic [`WDRL_IRQ_W-1:0] irq_en;
  logic [`WDRL_IRQ_W-1:0] irq_set;
  logic                   timeout;
  logic                   reset_mode;
  logic                   load;
  logic                   wr_ctrl;
  logic                   unlock_word;
  logic                   we_upper;
  logic                   we_high;
  logic                   we_low;
  logic [7:0]             reload_upper;
  logic [7:0]             reload_high;
  logic [7:0]             reload_low;

  assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  assign wr_ctrl     = bus.wr && (bus.addr == `WDRL_OFF_CTRL);
  assign unlock_word = (bus.wdata == `WDRL_UNLOCK_1) || (bus.wdata == `WDRL_UNLOCK_2);
  assign reset_mode  = ctrl[`WDRL_CTRL_RST_BIT];

  // Lock machine: only the exact next step advances and a repeated 0x55 holds; any other write locks
  always_comb begin
    next_lock_state = lock_state;
    if (bus.wr) begin
      next_lock_state = wdrl_pkg::WDRL_LOCKED;
      unique case (lock_state)
        wdrl_pkg::WDRL_LOCKED: begin
          if (wr_ctrl && bus.wdata == `WDRL_UNLOCK_1) begin
            next_lock_state = wdrl_pkg::WDRL_GOT_55;
          end
        end
        wdrl_pkg::WDRL_GOT_55: begin
          if (wr_ctrl && bus.wdata == `WDRL_UNLOCK_2) begin
            next_lock_state = wdrl_pkg::WDRL_OPEN_UPPER;
          end else if (wr_ctrl && bus.wdata == `WDRL_UNLOCK_1) begin
            next_lock_state = wdrl_pkg::WDRL_GOT_55;
          end
        end
        wdrl_pkg::WDRL_OPEN_UPPER: begin
          if (bus.addr == `WDRL_OFF_UPPER) begin
            next_lock_state = wdrl_pkg::WDRL_OPEN_HIGH;
          end
        end
        wdrl_pkg::WDRL_OPEN_HIGH: begin
          // Low byte write is awaited here; reaching it relocks
          next_lock_state = wdrl_pkg::WDRL_LOCKED;
        end
      endcase
    end
  end

  // Third open step tracked separately so the enum stays four states
  logic high_done;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_state <= wdrl_pkg::WDRL_LOCKED;
    end else if (lock_state == wdrl_pkg::WDRL_OPEN_HIGH && bus.wr && !high_done
                 && bus.addr == `WDRL_OFF_HIGH) begin
      lock_state <= wdrl_pkg::WDRL_OPEN_HIGH;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_done <= 1'b0;
    end else if (bus.wr) begin
      high_done <= (lock_state == wdrl_pkg::WDRL_OPEN_HIGH) && !high_done
                   && (bus.addr == `WDRL_OFF_HIGH);
    end
  end

  // Reload bytes: writable only at their own step of an open sequence
  assign we_upper = bus.wr && (lock_state == wdrl_pkg::WDRL_OPEN_UPPER)
                    && (bus.addr == `WDRL_OFF_UPPER);
  assign we_high  = bus.wr && (lock_state == wdrl_pkg::WDRL_OPEN_HIGH) && !high_done
                    && (bus.addr == `WDRL_OFF_HIGH);
  assign we_low   = bus.wr && (lock_state == wdrl_pkg::WDRL_OPEN_HIGH) && high_done
                    && (bus.addr == `WDRL_OFF_LOW);
  assign reload   = '{upper: reload_upper, high: reload_high, low: reload_low};

  // Reset value split per byte; the counter sees all three as one word
  wdrl_gated_byte #(
    .RESET_VAL (8'(`WDRL_RELOAD_RESET >> 16))
  ) u_reload_upper (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (we_upper),
    .d     (bus.wdata),
    .q     (reload_upper)
  );

  wdrl_gated_byte #(
    .RESET_VAL (8'(`WDRL_RELOAD_RESET >> 8))
  ) u_reload_high (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (we_high),
    .d     (bus.wdata),
    .q     (reload_high)
  );

  wdrl_gated_byte #(
    .RESET_VAL (8'(`WDRL_RELOAD_RESET))
  ) u_reload_low (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (we_low),
    .d     (bus.wdata),
    .q     (reload_low)
  );

  // Unlock values are sequence input only and never stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `WDRL_CTRL_RESET;
    end else if (wr_ctrl && !unlock_word) begin
      ctrl <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enabled_q <= 1'b0;
    end else begin
      enabled_q <= ctrl[`WDRL_CTRL_EN_BIT];
    end
  end

  assign load    = (ctrl[`WDRL_CTRL_EN_BIT] && !enabled_q) || refresh;
  assign timeout = enabled_q && !load && count_tick && (count == 24'h000001);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 24'hffffff;
    end else if (load) begin
      count <= reload;
    end else if (timeout) begin
      count <= reload;
    end else if (enabled_q && count_tick) begin
      count <= count - 24'h000001;
    end
  end

  // Reset-on-time-out splits on stop mode; sticky cause flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_req     <= 1'b0;
      stop_recovery_req <= 1'b0;
    end else begin
      sys_reset_req     <= timeout && reset_mode && !stop_mode;
      stop_recovery_req <= timeout && reset_mode && stop_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause <= `WDRL_CAUSE_RESET;
    end else if (timeout && reset_mode) begin
      cause[`WDRL_CAUSE_WDT_BIT]  <= 1'b1;
      cause[`WDRL_CAUSE_STOP_BIT] <= stop_mode;
    end else if (bus.rd && bus.addr == `WDRL_OFF_CAUSE) begin
      cause <= `WDRL_CAUSE_RESET;
    end
  end

  assign irq_set[`WDRL_IRQ_TIMEOUT_BIT] = timeout;
  assign irq_set[`WDRL_IRQ_NORM_BIT]    = timeout && reset_mode && !stop_mode;
  assign irq_set[`WDRL_IRQ_STOP_BIT]    = timeout && reset_mode && stop_mode;

  // Set wins over a same-cycle clear
  wdrl_sticky_flags #(
    .W (`WDRL_IRQ_W)
  ) u_irq_stat (
    .clk    (clk),
    .rst_b  (rst_b),
    .set    (irq_set),
    .clr_we (bus.wr && (bus.addr == `WDRL_OFF_IRQ_CLR)),
    .clr    (bus.wdata[`WDRL_IRQ_W-1:0]),
    .flags  (irq_stat)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en <= '0;
    end else if (bus.wr && bus.addr == `WDRL_OFF_IRQ_EN) begin
      irq_en <= bus.wdata[`WDRL_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat | irq_set) & irq_en);
    end
  end

  // Read data one cycle after the strobe; unmapped and idle read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `WDRL_OFF_CTRL:     rdata <= ctrl;
        `WDRL_OFF_UPPER:    rdata <= reload.upper;
        `WDRL_OFF_HIGH:     rdata <= reload.high;
        `WDRL_OFF_LOW:      rdata <= reload.low;
        `WDRL_OFF_CAUSE:    rdata <= cause;
        `WDRL_OFF_COUNT_U:  rdata <= count[23:16];
        `WDRL_OFF_COUNT_H:  rdata <= count[15:8];
        `WDRL_OFF_COUNT_L:  rdata <= count[7:0];
        `WDRL_OFF_IRQ_STAT: rdata <= {5'h00, irq_stat};
        `WDRL_OFF_IRQ_EN:   rdata <= {5'h00, irq_en};
        default:            rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : wdrl_watchdog

// Byte register behind a write gate; the gate carries the lock decision
module wdrl_gated_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       we,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RESET_VAL;
    end else if (we) begin
      q <= d;
    end
  end

endmodule : wdrl_gated_byte

// Sticky flags; a set in the clearing cycle survives so no event is lost
module wdrl_sticky_flags #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] set,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= '0;
    end else if (clr_we) begin
      flags <= (flags & ~clr) | set;
    end else begin
      flags <= flags | set;
    end
  end

endmodule : wdrl_sticky_flags

// ===== testbench/wdrl_watchdog_asserts.sv
// Port checker for the watchdog reload/lock block.
// Bound to every wdrl_watchdog instance; sees its ports only.
`timescale 1ns/10ps
`include "wdrl_consts.svh"
module wdrl_watchdog_asserts (
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    rd,
  input wire logic [`WDRL_ADDR_W-1:0] addr,
  input wire logic [7:0]              rdata,
  input wire logic                    count_tick,
  input wire logic                    stop_mode,
  input wire logic                    sys_reset_req,
  input wire logic                    stop_recovery_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_any_req;
    sys_reset_req || stop_recovery_req;
  endsequence
  sequence s_cause_rd;
    rd && addr == `WDRL_OFF_CAUSE;
  endsequence
  chk_req_excl: assert property (!(sys_reset_req && stop_recovery_req))
    else $error("both reset requests high");
  chk_norm_reset: assert property (sys_reset_req |-> !$past(stop_mode))
    else $error("system reset while stopped");
  chk_stop_recover: assert property (stop_recovery_req |-> $past(stop_mode))
    else $error("stop recovery outside stop mode");
  chk_req_tick: assert property (s_any_req |-> $past(count_tick))
    else $error("request without a tick");
  chk_req_pulse: assert property (s_any_req |=> !(sys_reset_req || stop_recovery_req))
    else $error("request longer than one cycle");
  chk_norm_cause: assert property (sys_reset_req ##1 s_cause_rd |=> rdata == 8'h40)
    else $error("cause wrong after normal timeout");
  chk_stop_cause: assert property (stop_recovery_req ##1 s_cause_rd |=> rdata == 8'h60)
    else $error("cause wrong after stop timeout");
  // Read data must idle at zero, or stale values leak
  chk_rdata_idle: assert property (rdata != 8'h00 |-> $past(rd))
    else $error("read data outside read cycle");
endmodule : wdrl_watchdog_asserts

bind wdrl_watchdog wdrl_watchdog_asserts u_chk (.clk(clk), .rst_b(rst_b), .rd(rd), .addr(addr),
  .rdata(rdata), .count_tick(count_tick), .stop_mode(stop_mode), .sys_reset_req(sys_reset_req),
  .stop_recovery_req(stop_recovery_req));

// ===== testbench/tb_wdrl_watchdog.sv
// Self-checking bench for the watchdog reload/lock block.
// Drives register port, refresh and stop level directly; the tick is tick_on registered one clock later.
`timescale 1ns/10ps
`include "wdrl_consts.svh"
module tb_wdrl_watchdog;
  logic                    clk, rst_b, wr, rd, tick_on, count_tick, refresh, stop_mode;
  logic                    sys_reset_req, stop_recovery_req, irq, hit;
  logic [`WDRL_ADDR_W-1:0] addr;
  logic [7:0]              wdata, rdata, lo;
  int                      bad_count, compares, i, n;
  wdrl_watchdog uut (.clk(clk), .rst_b(rst_b), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .count_tick(count_tick), .refresh(refresh), .stop_mode(stop_mode),
    .sys_reset_req(sys_reset_req), .stop_recovery_req(stop_recovery_req), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) count_tick <= tick_on;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_cause(input logic stop);
    logic [7:0] c;
    c = 8'h00;
    c[`WDRL_CAUSE_WDT_BIT] = 1'b1;
    c[`WDRL_CAUSE_STOP_BIT] = stop;
    return c;
  endfunction : exp_cause
  function automatic logic [7:0] exp_stat(input logic rst_mode, input logic stop);
    logic [7:0] s;
    s = 8'h00;
    s[`WDRL_IRQ_TIMEOUT_BIT] = 1'b1;
    s[`WDRL_IRQ_NORM_BIT] = rst_mode && !stop;
    s[`WDRL_IRQ_STOP_BIT] = rst_mode && stop;
    return s;
  endfunction : exp_stat
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd_chk
  // Ticks every cycle; one extra tick lands after the stop
  task automatic wait_req(input logic stop);
    tick_on <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((stop ? stop_recovery_req : sys_reset_req) !== 1'b1 && n < 60);
    tick_on <= 1'b0;
    chk(8'(n < 60), 8'h01);
  endtask : wait_req
  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    bad_count++;
    finish_test;
  end
  initial begin
    {rst_b, wr, rd, tick_on, refresh, stop_mode} = 6'h00;
    addr = 4'h0;
    wdata = 8'h00;
    bad_count = 0;
    compares = 0;
    void'($urandom(32'h46a2c742));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 6; i++) wr_reg(4'(1 + i % 3), 8'($urandom));
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h2, 8'h04);
    rd_chk(4'h3, 8'h00);
    $display("locked test done");
    wr_reg(4'h0, 8'h02);
    wr_reg(4'h0, 8'h55);
    wr_reg(4'h0, 8'haa);
    rd_chk(4'h0, 8'h02);
    wr_reg(4'ha, 8'h07);
    wr_reg(4'h1, 8'h5a);
    rd_chk(4'h1, 8'h00);
    lo = 8'(2 + $urandom % 6);
    wr_reg(4'h0, 8'h55);
    wr_reg(4'h0, 8'haa);
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h3, lo);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h3, lo);
    wr_reg(4'h2, 8'h33);
    rd_chk(4'h2, 8'h00);
    wr_reg(4'h0, 8'h55);
    wr_reg(4'h0, 8'haa);
    wr_reg(4'h2, 8'h66);
    wr_reg(4'h3, 8'h66);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h3, lo);
    $display("unlock test done");
    wr_reg(4'h0, 8'h03);
    repeat (2) @(posedge clk);
    rd_chk(4'h7, lo);
    rd_chk(4'h6, 8'h00);
    wait_req(1'b0);
    rd_chk(4'h4, exp_cause(1'b0));
    rd_chk(4'h8, exp_stat(1'b1, 1'b0));
    chk({7'h00, irq}, 8'h01);
    wr_reg(4'h9, 8'h07);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    $display("normal timeout test done");
    @(posedge clk);
    stop_mode <= 1'b1;
    wait_req(1'b1);
    rd_chk(4'h4, exp_cause(1'b1));
    @(posedge clk);
    refresh <= 1'b1;
    @(posedge clk);
    refresh <= 1'b0;
    rd_chk(4'h7, lo);
    wr_reg(4'ha, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    rd_chk(4'h8, exp_stat(1'b1, 1'b1));
    $display("stop timeout test done");
    wr_reg(4'h0, 8'h01);
    wr_reg(4'h9, 8'h07);
    hit = 1'b0;
    tick_on <= 1'b1;
    repeat (20) begin
      @(negedge clk);
      hit = hit | sys_reset_req | stop_recovery_req;
    end
    tick_on <= 1'b0;
    chk({7'h00, hit}, 8'h00);
    rd_chk(4'h8, exp_stat(1'b0, 1'b1));
    rd_chk(4'h4, 8'h00);
    $display("no reset timeout test done");
    finish_test;
  end
endmodule : tb_wdrl_watchdog
